// *** pkg/pin_ctrl_pkg.sv ***
// Shared constants and carrier types for the pin strap and wake-up control block.
// Assumes a 40 MHz reference clock and a classic Wishbone master with 32-bit data.
package pin_ctrl_pkg;

  // Clock rate and LED stretch time.
  localparam int CLK_KHZ            = 40000;
  localparam int LED_STRETCH_US     = 50000;
  localparam int LED_STRETCH_CYCLES = LED_STRETCH_US * (CLK_KHZ / 1000);

  // Register byte offsets.
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG    = 8'h04;
  localparam logic [7:0] ADDR_FUNC_OPT  = 8'h08;
  localparam logic [7:0] ADDR_FUNC_STAT = 8'h0c;
  localparam logic [7:0] ADDR_STRAPS    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

  // Field positions.
  localparam int CTL_WAKE_EN_BIT = 0;
  localparam int CTL_PWR_DN_BIT  = 1;
  localparam int CFG_WIDE_BIT    = 7;
  localparam int FOPT_FEN_BIT    = 0;
  localparam int FSTAT_PD_BIT    = 2;

  // Interrupt events.
  localparam int EV_W         = 3;
  localparam int EV_WAKE_BIT  = 0;
  localparam int EV_ARM_BIT   = 1;
  localparam int EV_DISARM_BIT = 2;

  // Values after reset.
  localparam logic            RST_WAKE_EN  = 1'b0;
  localparam logic            RST_CTL_PD   = 1'b0;
  localparam logic            RST_CFG_WIDE = 1'b0;
  localparam logic            RST_FEN      = 1'b0;
  localparam logic            RST_FPD      = 1'b0;
  localparam logic [EV_W-1:0] RST_IRQ_MASK = 3'h0;

  // Number of pin inputs that pass the synchroniser.
  localparam int SYNC_W = 15;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Output half of a two-way or open-drain pin.
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module pin_sync
  import pin_ctrl_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st      = st;
    next_st.meta = i_async;
    next_st.safe = st.meta;
  end

  // State register, reset to the pulled-up idle levels.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_sync = st.safe;

endmodule // pin_sync

// *** rtl/led_stretch.sv ***
// Retriggerable pulse stretcher for an activity LED.
// Assumes the trigger is already synchronous to the clock.
`timescale 1ns/1ps
module led_stretch
  import pin_ctrl_pkg::*;
#(
  parameter int CYCLES = LED_STRETCH_CYCLES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  input  wire logic i_trig,
  output logic      o_active
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          active;
  } stretch_state_t;

  stretch_state_t st;
  stretch_state_t next_st;

  // Reload while the access lasts, then count down to zero.
  always_comb begin
    next_st = st;
    if (i_trig) begin
      next_st.cnt = CW'(CYCLES);
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CW'(1);
    end
    next_st.active = i_trig | (next_st.cnt != '0);
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_active = st.active;

endmodule // led_stretch

// *** rtl/pin_strap_wakeup_control.sv ***
// Pin-level control: activity LED, bus-width and EEPROM straps, codec select,
// power-down input and wake-up arming, with a Wishbone register file.
// Assumes a classic Wishbone master on the same clock and pins from outside it.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps

// Behaviour
// - ISA mode: LED lights on I/O strobe with AEN low and valid decode.
// - PCMCIA mode: LED lights on I/O access when register select low and function enabled.
// - Each LED pulse is stretched beyond the access that caused it.
// - EEPROM access is allowed only while the EEPROM-enable strap is high.
// - Bus is 16 bits when the width strap is low, else 8 bits.
// - Software or EEPROM contents (ISA only) may also select the 16-bit bus.
// - Codec-select strap low picks external codec, open picks internal codec.
// - External codec: shared transmit pins are collision and carrier sense inputs.
// - External codec supplies receive data and clocks; device drives transmit data.
// - Internal codec: shared pins drive receive-activity and link-status LEDs.
// - Internal codec: power-down input high or open keeps the device powered down.
// - Arming pin low enables wake frame detection and powers the network down.
// - While armed, the pin overrides wake, power-down and function-enable bits.
// - On disarm, wake, both power-down bits clear and function enable sets.
// - Wake output rises when armed and a valid wake frame is detected.
// - Wake output holds high until the arming pin is released.
module pin_strap_wakeup_control
  import pin_ctrl_pkg::*;
#(
  parameter int STRETCH_CYCLES = LED_STRETCH_CYCLES
) (
  input  wire logic    i_ref_clk,
  input  wire logic    i_rst_n,
  input  wire logic    i_clk_en,
  input  wire wb_req_t i_wb,
  output wb_rsp_t      o_wb,
  input  wire logic    i_pcmcia_mode,
  input  wire logic    i_io_rd_n,
  input  wire logic    i_io_wr_n,
  input  wire logic    i_aen,
  input  wire logic    i_addr_valid,
  input  wire logic    i_reg_n,
  input  wire logic    i_eeprom_enable_strap,
  input  wire logic    i_wide_bus_strap_n,
  input  wire logic    i_external_codec_select_n,
  input  wire logic    i_power_down_or_tx_clock,
  input  wire logic    i_wake_arm_n,
  input  wire logic    i_aui_tx_pos_or_collision_n,
  input  wire logic    i_aui_tx_neg_or_carrier_n,
  input  wire logic    i_board_led_or_rx_data,
  input  wire logic    i_rx_led_or_rx_clock,
  input  wire logic    i_eeprom_wide,
  input  wire logic    i_wake_frame,
  input  wire logic    i_rx_activity,
  input  wire logic    i_link_up,
  input  wire logic    i_tx_data,
  output pin_drive_t   o_board_activity_led_n,
  output pin_drive_t   o_receive_activity_led_n,
  output pin_drive_t   o_link_status_led_n,
  output logic         o_wide_bus,
  output logic         o_eeprom_access_enable,
  output logic         o_external_codec,
  output logic         o_net_power_down,
  output logic         o_wake_detect_enable,
  output logic         o_wake,
  output logic         o_collision,
  output logic         o_carrier_sense,
  output logic         o_ext_rx_data,
  output logic         o_ext_codec_rx_clock,
  output logic         o_ext_codec_tx_clock,
  output logic         o_irq
);

  typedef struct packed {
    wb_rsp_t         wb;
    logic            wake_en;
    logic            ctl_pd;
    logic            cfg_wide;
    logic            fen;
    logic            fpd;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic            armed;
    logic            wake;
    pin_drive_t      bled;
    pin_drive_t      rxled;
    pin_drive_t      lnkled;
    logic            wide;
    logic            eep;
    logic            ext;
    logic            npd;
    logic            wden;
    logic            col;
    logic            crs;
    logic            rxd;
    logic            rx_clk;
    logic            tx_clk;
    logic            irq;
  } ctrl_state_t;

  ctrl_state_t       st;
  ctrl_state_t       next_st;
  logic        [1:0] rst_pipe;
  logic              rst_n;
  logic [SYNC_W-1:0] pins;
  logic              led_on;

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // All pin inputs pass two flip-flops before use.
  pin_sync #(
    .W       (SYNC_W),
    .RST_VAL ('1)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_pcmcia_mode, i_io_rd_n, i_io_wr_n, i_aen, i_addr_valid,
                 i_reg_n, i_eeprom_enable_strap, i_wide_bus_strap_n,
                 i_external_codec_select_n, i_power_down_or_tx_clock,
                 i_wake_arm_n, i_aui_tx_pos_or_collision_n,
                 i_aui_tx_neg_or_carrier_n, i_board_led_or_rx_data,
                 i_rx_led_or_rx_clock}),
    .o_sync    (pins)
  );

  // Synchronised pin levels by name.
  logic pcmcia;
  logic rd_n;
  logic wr_n;
  logic aen;
  logic addr_ok;
  logic reg_n;
  logic eep_strap;
  logic wide_n;
  logic xsel_n;
  logic pd_pin;
  logic arm_n;
  logic col_n;
  logic crs_n;
  logic pin_rxd;
  logic pin_rx_clk;

  assign {pcmcia, rd_n, wr_n, aen, addr_ok, reg_n, eep_strap, wide_n,
          xsel_n, pd_pin, arm_n, col_n, crs_n, pin_rxd, pin_rx_clk} = pins;

  // Access detection for the board-activity LED.
  logic io_strobe;
  logic access;

  assign io_strobe = ~rd_n | ~wr_n;
  assign access    = pcmcia ? (io_strobe & ~reg_n & st.fen)
                            : (io_strobe & ~aen & addr_ok);

  led_stretch #(
    .CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_clk_en  (i_clk_en),
    .i_trig    (access),
    .o_active  (led_on)
  );

  // Bus decode terms.
  logic            hit;
  logic            wr;
  logic            rd;
  logic            arm;
  logic            ext;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] rclr;
  logic [31:0]     rdata;

  assign hit = i_wb.cyc & i_wb.stb & ~st.wb.ack;
  assign wr  = hit & i_wb.we & i_wb.sel[0];
  assign rd  = hit & ~i_wb.we;
  assign arm = ~arm_n;
  assign ext = ~xsel_n;

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdata = '0;
    unique case (i_wb.adr)
      ADDR_CONTROL: begin
        rdata[CTL_WAKE_EN_BIT] = st.wake_en;
        rdata[CTL_PWR_DN_BIT]  = st.ctl_pd;
      end
      ADDR_CONFIG: begin
        rdata[CFG_WIDE_BIT] = st.cfg_wide;
      end
      ADDR_FUNC_OPT: begin
        rdata[FOPT_FEN_BIT] = st.fen;
      end
      ADDR_FUNC_STAT: begin
        rdata[FSTAT_PD_BIT] = st.fpd;
      end
      ADDR_STRAPS: begin
        rdata[5:0] = {st.wake, st.armed, st.npd, st.eep, st.ext, st.wide};
      end
      ADDR_IRQ_STAT: begin
        rdata[EV_W-1:0] = st.irq_stat;
      end
      ADDR_IRQ_MASK: begin
        rdata[EV_W-1:0] = st.irq_mask;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  // Events that set the sticky interrupt bits.
  always_comb begin
    ev                = '0;
    ev[EV_WAKE_BIT]   = arm & i_wake_frame & ~st.wake;
    ev[EV_ARM_BIT]    = arm & ~st.armed;
    ev[EV_DISARM_BIT] = ~arm & st.armed;
    rclr              = '0;
    if (rd && i_wb.adr == ADDR_IRQ_STAT) begin
      rclr = st.irq_stat;
    end
  end

  // Next-state logic for registers, pins and flags.
  always_comb begin
    next_st = st;

    // One-cycle acknowledge for every request, mapped or not.
    next_st.wb.ack = hit;
    next_st.wb.dat = rd ? rdata : '0;

    // Software writes, ignored for overridden bits while armed.
    if (wr && !arm) begin
      unique case (i_wb.adr)
        ADDR_CONTROL: begin
          next_st.wake_en = i_wb.dat[CTL_WAKE_EN_BIT];
          next_st.ctl_pd  = i_wb.dat[CTL_PWR_DN_BIT];
        end
        ADDR_FUNC_OPT: begin
          next_st.fen = i_wb.dat[FOPT_FEN_BIT];
        end
        ADDR_FUNC_STAT: begin
          next_st.fpd = i_wb.dat[FSTAT_PD_BIT];
        end
        default: begin
          next_st.fen = st.fen;
        end
      endcase
    end
    if (wr && i_wb.adr == ADDR_CONFIG) begin
      next_st.cfg_wide = i_wb.dat[CFG_WIDE_BIT];
    end
    if (wr && i_wb.adr == ADDR_IRQ_MASK) begin
      next_st.irq_mask = i_wb.dat[EV_W-1:0];
    end

    // The arming pin forces the control bits while it is held low.
    if (arm) begin
      next_st.wake_en = 1'b1;
      next_st.ctl_pd  = 1'b1;
      next_st.fpd     = 1'b1;
      next_st.fen     = 1'b0;
    end else if (st.armed) begin
      next_st.wake_en = 1'b0;
      next_st.ctl_pd  = 1'b0;
      next_st.fpd     = 1'b0;
      next_st.fen     = 1'b1;
    end
    next_st.armed = arm;
    next_st.wden  = arm;

    // Wake output latches on a detected frame and drops on disarm.
    if (!arm) begin
      next_st.wake = 1'b0;
    end else if (i_wake_frame) begin
      next_st.wake = 1'b1;
    end

    // Straps and bus width.
    next_st.eep  = eep_strap;
    next_st.ext  = ext;
    next_st.wide = ~wide_n | st.cfg_wide | (~pcmcia & i_eeprom_wide);

    // Network power-down from the pin, the control bits and arming.
    next_st.npd = arm | st.ctl_pd | st.fpd | (~ext & pd_pin);

    // Shared pins: LEDs sink current on the internal codec.
    next_st.bled.out   = 1'b0;
    next_st.bled.oe    = ~ext & led_on;
    next_st.rxled.out  = 1'b0;
    next_st.rxled.oe   = ~ext & i_rx_activity;
    next_st.lnkled.out = ext ? i_tx_data : 1'b0;
    next_st.lnkled.oe  = ext | i_link_up;

    // Codec inputs on the external codec, idle otherwise.
    next_st.col    = ext & ~col_n;
    next_st.crs    = ext & ~crs_n;
    next_st.rxd    = ext & pin_rxd;
    next_st.rx_clk = ext & pin_rx_clk;
    next_st.tx_clk = ext & pd_pin;

    // Sticky interrupt bits; a new event wins over the read clear.
    next_st.irq_stat = (st.irq_stat & ~rclr) | ev;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.wake_en  <= RST_WAKE_EN;
      st.ctl_pd   <= RST_CTL_PD;
      st.cfg_wide <= RST_CFG_WIDE;
      st.fen      <= RST_FEN;
      st.fpd      <= RST_FPD;
      st.irq_mask <= RST_IRQ_MASK;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign o_wb                     = st.wb;
  assign o_board_activity_led_n   = st.bled;
  assign o_receive_activity_led_n = st.rxled;
  assign o_link_status_led_n      = st.lnkled;
  assign o_wide_bus               = st.wide;
  assign o_eeprom_access_enable   = st.eep;
  assign o_external_codec         = st.ext;
  assign o_net_power_down         = st.npd;
  assign o_wake_detect_enable     = st.wden;
  assign o_wake                   = st.wake;
  assign o_collision              = st.col;
  assign o_carrier_sense          = st.crs;
  assign o_ext_rx_data            = st.rxd;
  assign o_ext_codec_rx_clock     = st.rx_clk;
  assign o_ext_codec_tx_clock     = st.tx_clk;
  assign o_irq                    = st.irq;

endmodule // pin_strap_wakeup_control

// *** bench/pin_strap_wakeup_control_monitor.sv ***
// Checker for the pin strap and wake-up block, bound to its top ports.
// Assumes STRETCH_CYCLES equals the value of the bound instance.
`timescale 1ns/1ps
module pin_strap_wakeup_control_monitor
  import pin_ctrl_pkg::*;
#(
  parameter int STRETCH_CYCLES = LED_STRETCH_CYCLES
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire wb_req_t    i_wb,
  input wire wb_rsp_t    o_wb,
  input wire logic       i_wake_frame,
  input wire pin_drive_t o_board_activity_led_n,
  input wire logic       o_external_codec,
  input wire logic       o_net_power_down,
  input wire logic       o_wake_detect_enable,
  input wire logic       o_wake,
  input wire logic       o_collision,
  input wire logic       o_carrier_sense
);
  int unsigned run;
  // Counts the cycles the board LED has been lit in a row.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run <= 0;
    end else begin
      run <= o_board_activity_led_n.oe ? run + 32'd1 : 32'd0;
    end
  end
  default clocking dc @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_ack_has_req: assert property (o_wb.ack |-> $past(i_wb.cyc & i_wb.stb))
    else $error("ack without a request.");
  a_ack_one_cycle: assert property (o_wb.ack |=> !o_wb.ack)
    else $error("ack longer than one cycle.");
  a_dat_idle_zero: assert property (!o_wb.ack |-> o_wb.dat == 32'h0)
    else $error("read data not zero outside ack.");
  a_led_stretch_min: assert property (
    $fell(o_board_activity_led_n.oe) |-> run >= STRETCH_CYCLES)
    else $error("board LED pulse too short.");
  a_led_ext_dark: assert property (o_external_codec |-> !o_board_activity_led_n.oe)
    else $error("board LED lit in external codec mode.");
  a_int_no_coll: assert property (
    !o_external_codec && $past(!o_external_codec) |-> !o_collision && !o_carrier_sense)
    else $error("collision or carrier in internal mode.");
  a_wake_cause: assert property (
    $rose(o_wake) |-> $past(i_wake_frame) && o_wake_detect_enable)
    else $error("wake rose without armed frame.");
  a_armed_power_down: assert property (o_wake_detect_enable |-> o_net_power_down)
    else $error("armed but network not powered down.");
  a_wake_held: assert property ($fell(o_wake) |-> !o_wake_detect_enable)
    else $error("wake dropped while armed.");
  a_wake_release: assert property ($fell(o_wake_detect_enable) |-> ##[0:1] !o_wake)
    else $error("wake stayed after disarm.");
endmodule // pin_strap_wakeup_control_monitor

bind pin_strap_wakeup_control pin_strap_wakeup_control_monitor #(
  .STRETCH_CYCLES(STRETCH_CYCLES)
) mon (.i_ref_clk, .i_rst_n, .i_wb, .o_wb, .i_wake_frame, .o_board_activity_led_n,
  .o_external_codec, .o_net_power_down, .o_wake_detect_enable, .o_wake,
  .o_collision, .o_carrier_sense);

// *** bench/ext_codec_model.sv ***
// External line codec model on the shared pins.
// Assumes the bench activates it only in external codec mode.
`timescale 1ns/1ps
module ext_codec_model (
  input  wire logic i_ref_clk,
  input  wire logic i_active,
  input  wire logic i_coll,
  input  wire logic i_crs,
  output logic      o_rx_clock,
  output logic      o_tx_clock,
  output logic      o_rx_data,
  output logic      o_coll_n,
  output logic      o_crs_n
);
  logic ph = 1'b0;
  // Phase toggles each cycle; idle pins rest at their pull-up level.
  always @(posedge i_ref_clk) begin
    ph <= ~ph;
  end
  assign o_rx_clock = i_active ? ph : 1'b1;
  assign o_tx_clock = i_active ? ~ph : 1'b1;
  assign o_rx_data  = i_active ? ph : 1'b1;
  assign o_coll_n   = ~(i_active & i_coll);
  assign o_crs_n    = ~(i_active & i_crs);
endmodule // ext_codec_model

// *** bench/tb_pin_strap_wakeup_control.sv ***
// Self-checking bench for the pin strap and wake-up block.
// Assumes a shortened LED stretch of 8 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h seen %h", nm, e, s); error_cnt++; end end
module tb_pin_strap_wakeup_control;
  import pin_ctrl_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, pcm = 1'b0, rd_n = 1'b1, wr_n = 1'b1, ce = 1'b1;
  logic       aen = 1'b0, av = 1'b0, reg_n = 1'b1, eep = 1'b1, wide_n = 1'b1;
  logic       ext = 1'b0, pd_lvl = 1'b1, arm_n = 1'b1, eew = 1'b0, frame = 1'b0;
  logic       rxa = 1'b0, lnk = 1'b0, txd = 1'b0, coll = 1'b0, crs = 1'b0, b;
  wb_req_t    req = '0;
  wb_rsp_t    rsp;
  pin_drive_t bled, rled, kled;
  logic       wide, eea, xc, npd, wde, wake, col, crsd, erd, erc, etc, irq;
  wire logic  m_rxc, m_txc, m_rxd, m_cn, m_sn;
  int         error_cnt = 0, checked = 0;
  logic [31:0] q;
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  ext_codec_model codec (.i_ref_clk(clk), .i_active(ext), .i_coll(coll), .i_crs(crs),
    .o_rx_clock(m_rxc), .o_tx_clock(m_txc), .o_rx_data(m_rxd), .o_coll_n(m_cn),
    .o_crs_n(m_sn));
  pin_strap_wakeup_control #(.STRETCH_CYCLES(8)) uut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_wb(req), .o_wb(rsp),
    .i_pcmcia_mode(pcm), .i_io_rd_n(rd_n), .i_io_wr_n(wr_n), .i_aen(aen),
    .i_addr_valid(av), .i_reg_n(reg_n), .i_eeprom_enable_strap(eep),
    .i_wide_bus_strap_n(wide_n), .i_external_codec_select_n(~ext),
    .i_power_down_or_tx_clock(ext ? m_txc : pd_lvl), .i_wake_arm_n(arm_n),
    .i_aui_tx_pos_or_collision_n(m_cn), .i_aui_tx_neg_or_carrier_n(m_sn),
    .i_board_led_or_rx_data(bled.oe ? bled.out : m_rxd),
    .i_rx_led_or_rx_clock(rled.oe ? rled.out : m_rxc), .i_eeprom_wide(eew),
    .i_wake_frame(frame), .i_rx_activity(rxa), .i_link_up(lnk), .i_tx_data(txd),
    .o_board_activity_led_n(bled), .o_receive_activity_led_n(rled),
    .o_link_status_led_n(kled), .o_wide_bus(wide), .o_eeprom_access_enable(eea),
    .o_external_codec(xc), .o_net_power_down(npd), .o_wake_detect_enable(wde),
    .o_wake(wake), .o_collision(col), .o_carrier_sense(crsd), .o_ext_rx_data(erd),
    .o_ext_codec_rx_clock(erc), .o_ext_codec_tx_clock(etc), .o_irq(irq));
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Waits n edges, then settles on the falling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One classic Wishbone cycle; read data lands in q.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    q = rsp.dat;
    req <= '0;
    if (rsp.ack !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("read", e, q)
  endtask
  // A strobe of three cycles, then the LED state and its drain time.
  task automatic access(input logic e, input logic w);
    int n;
    @(posedge clk);
    {rd_n, wr_n} <= w ? 2'b10 : 2'b01;
    repeat (3) @(posedge clk);
    {rd_n, wr_n} <= 2'b11;
    tick(3);
    `CHK("led", e, bled.oe)
    for (n = 0; n < 30 && bled.oe === 1'b1; n++) tick(0);
    `CHK("stretch", 1'b1, e ? n >= 4 && n < 30 : n == 0)
  endtask
  task automatic t_regs();
    chk_rd(ADDR_CONTROL, 32'h0);
    chk_rd(ADDR_CONFIG, 32'h0);
    chk_rd(ADDR_FUNC_OPT, 32'h0);
    chk_rd(ADDR_IRQ_MASK, 32'h0);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    chk_rd(8'h40, 32'h0);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_straps();
    @(posedge clk);
    {eep, wide_n} <= 2'b00;
    tick(5);
    `CHK("eeprom", 1'b0, eea)
    `CHK("wide", 1'b1, wide)
    @(posedge clk);
    {ce, eep, wide_n} <= 3'b011;
    tick(5);
    `CHK("frozen", 2'b01, {eea, wide})
    @(posedge clk);
    ce <= 1'b1;
    tick(5);
    `CHK("eeprom", 1'b1, eea)
    `CHK("wide", 1'b0, wide)
    wb(1'b1, ADDR_CONFIG, 32'h80);
    tick(2);
    `CHK("wide", 1'b1, wide)
    wb(1'b1, ADDR_CONFIG, 32'h0);
    @(posedge clk);
    eew <= 1'b1;
    tick(3);
    `CHK("wide", 1'b1, wide)
    @(posedge clk);
    pcm <= 1'b1;
    tick(5);
    `CHK("wide", 1'b0, wide)
    @(posedge clk);
    {pcm, eew, av, aen} <= 4'b0011;
  endtask
  task automatic t_led();
    access(1'b0, 1'b0);
    @(posedge clk);
    {av, aen} <= 2'b00;
    access(1'b0, 1'b1);
    @(posedge clk);
    av <= 1'b1;
    access(1'b1, 1'b0);
    access(1'b1, 1'b1);
    @(posedge clk);
    {pcm, reg_n} <= 2'b10;
    access(1'b0, 1'b0);
    wb(1'b1, ADDR_FUNC_OPT, 32'h1);
    access(1'b1, 1'b1);
    @(posedge clk);
    reg_n <= 1'b1;
    access(1'b0, 1'b0);
    wb(1'b1, ADDR_FUNC_OPT, 32'h0);
    @(posedge clk);
    pcm <= 1'b0;
  endtask
  task automatic t_codec();
    `CHK("pd", 1'b1, npd)
    @(posedge clk);
    {pd_lvl, rxa, lnk} <= 3'b011;
    tick(5);
    `CHK("pd", 1'b0, npd)
    `CHK("leds", 2'b11, {rled.oe, kled.oe})
    `CHK("codec", 1'b0, xc)
    @(posedge clk);
    ext <= 1'b1;
    tick(5);
    `CHK("codec", 1'b1, xc)
    `CHK("pd", 1'b0, npd)
    `CHK("rx led", 1'b0, rled.oe)
    access(1'b0, 1'b0);
    @(posedge clk);
    {coll, crs, txd} <= 3'b111;
    tick(5);
    `CHK("coll crs", 2'b11, {col, crsd})
    `CHK("txd", 2'b11, {kled.oe, kled.out})
    b = etc;
    tick(0);
    `CHK("tx clock", ~b, etc)
    `CHK("rx clock", b, erc)
    `CHK("rx data", b, erd)
    @(posedge clk);
    {coll, crs, txd, ext} <= 4'b0000;
    tick(5);
    `CHK("coll crs", 2'b00, {col, crsd})
  endtask
  task automatic t_wake();
    wb(1'b1, ADDR_IRQ_MASK, 32'h7);
    wb(1'b1, ADDR_FUNC_STAT, 32'h4);
    wb(1'b1, ADDR_FUNC_OPT, 32'h1);
    @(posedge clk);
    frame <= 1'b1;
    tick(2);
    `CHK("wake", 1'b0, wake)
    @(posedge clk);
    {frame, arm_n} <= 2'b00;
    tick(4);
    `CHK("armed", 2'b11, {wde, npd})
    wb(1'b1, ADDR_CONTROL, 32'h0);
    chk_rd(ADDR_CONTROL, 32'h3);
    chk_rd(ADDR_FUNC_OPT, 32'h0);
    chk_rd(ADDR_FUNC_STAT, 32'h4);
    @(posedge clk);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    tick(6);
    `CHK("wake", 2'b11, {wake, irq})
    chk_rd(ADDR_STRAPS, 32'h3c);
    chk_rd(ADDR_IRQ_STAT, 32'h3);
    tick(2);
    `CHK("irq", 1'b0, irq)
    @(posedge clk);
    arm_n <= 1'b1;
    tick(4);
    `CHK("wake", 2'b00, {wake, wde})
    chk_rd(ADDR_CONTROL, 32'h0);
    chk_rd(ADDR_FUNC_OPT, 32'h1);
    chk_rd(ADDR_FUNC_STAT, 32'h0);
    chk_rd(ADDR_IRQ_STAT, 32'h4);
  endtask
  // Reset for three cycles, then every scenario in turn.
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    t_regs();
    t_straps();
    t_led();
    t_codec();
    t_wake();
    results();
  end
endmodule // tb_pin_strap_wakeup_control
